//--- rtl/stg_gain.sv
// Volume stage: scales one channel by a 1 dB per step attenuation code.
`timescale 1ns/1ns
module stg_gain import stg_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic in_valid,
    input wire logic signed [15:0] in_sample,
    input wire logic [5:0] vol_code,
    output logic signed [15:0] out_sample_q
);
    logic [5:0] shift;
    logic [5:0] rem;
    logic [14:0] mant;
    logic signed [31:0] prod;
    logic signed [31:0] scaled;
    logic signed [15:0] sat;

    // Six codes make roughly one halving; the remainder picks the fine step.
    always_comb begin
        shift = vol_code / STG_DB_PER_SHIFT;
        rem = vol_code % STG_DB_PER_SHIFT;
        case (rem)
            6'h00: mant = STG_MANT_P2;
            6'h01: mant = STG_MANT_P1;
            6'h02: mant = STG_MANT_0;
            6'h03: mant = STG_MANT_M1;
            6'h04: mant = STG_MANT_M2;
            default: mant = STG_MANT_M3;
        endcase
        prod = in_sample * $signed({1'b0, mant});
        scaled = prod >>> (STG_GAIN_FRAC + 32'(shift));
        // Clamp so the +2 dB codes cannot wrap a full-scale sample.
        if (scaled > 32'sh0000_7fff) begin
            sat = 16'sh7fff;
        end else if (scaled < -32'sh0000_8000) begin
            sat = -16'sh8000;
        end else begin
            sat = scaled[15:0];
        end
    end

    // Output is held at zero while the tone is not running.
    always_ff @(posedge core_clk) begin
        if (!rst_n || !run) begin
            out_sample_q <= 16'sh0000;
        end else if (in_valid) begin
            out_sample_q <= sat;
        end
    end
endmodule

//--- rtl/stg_osc.sv
// Coupled-form recursive sine oscillator, one step per playback sample.
`timescale 1ns/1ns
module stg_osc import stg_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic step,
    input wire logic signed [15:0] sin_coef,
    input wire logic signed [15:0] cos_coef,
    output logic signed [15:0] sine_q
);
    logic signed [15:0] cosv_q;
    logic signed [32:0] x_sum;
    logic signed [32:0] y_sum;

    // Rotation by the programmed angle; coefficients are Q1.15.
    always_comb begin
        x_sum = 33'(cos_coef * cosv_q) - 33'(sin_coef * sine_q);
        y_sum = 33'(sin_coef * cosv_q) + 33'(cos_coef * sine_q);
    end

    // Start restarts the phase at zero so every tone begins cleanly.
    always_ff @(posedge core_clk) begin
        if (!rst_n || start) begin
            cosv_q <= STG_OSC_AMP;
            sine_q <= 16'sh0000;
        end else if (step) begin
            cosv_q <= x_sum[STG_COEF_FRAC +: 16];
            sine_q <= y_sum[STG_COEF_FRAC +: 16];
        end
    end
endmodule

//--- rtl/stg_pkg.sv
// Constants and types shared by the sine tone generator files.
package stg_pkg;
    // Register page and offsets of the tone registers.
    localparam logic [7:0] STG_TONE_PAGE = 8'h00;
    localparam logic [7:0] STG_PAGE_OFS = 8'h00;
    localparam logic [7:0] STG_LCTL_OFS = 8'h47;
    localparam logic [7:0] STG_RCTL_OFS = 8'h48;
    localparam logic [7:0] STG_LENH_OFS = 8'h49;
    localparam logic [7:0] STG_LENM_OFS = 8'h4a;
    localparam logic [7:0] STG_LENL_OFS = 8'h4b;
    localparam logic [7:0] STG_SINH_OFS = 8'h4c;
    localparam logic [7:0] STG_SINL_OFS = 8'h4d;
    localparam logic [7:0] STG_COSH_OFS = 8'h4e;
    localparam logic [7:0] STG_COSL_OFS = 8'h4f;
    localparam logic [7:0] STG_RSV_LO_OFS = 8'h50;
    localparam logic [7:0] STG_RSV_HI_OFS = 8'h73;

    // Reset values.
    localparam logic [7:0] STG_PAGE_RST = 8'h00;
    localparam logic [7:0] STG_CTL_RST = 8'h00;
    localparam logic [7:0] STG_LENH_RST = 8'h00;
    localparam logic [7:0] STG_LENM_RST = 8'h00;
    localparam logic [7:0] STG_LENL_RST = 8'hee;
    localparam logic [7:0] STG_SINH_RST = 8'h10;
    localparam logic [7:0] STG_SINL_RST = 8'hd8;
    localparam logic [7:0] STG_COSH_RST = 8'h7e;
    localparam logic [7:0] STG_COSL_RST = 8'he3;

    // Field positions and encodings.
    localparam int STG_ENA_BIT = 7;
    localparam int STG_RSV_BIT = 6;
    localparam int STG_VOL_W = 6;
    localparam logic [1:0] STG_LINK_L_FROM_R = 2'h1;
    localparam logic [1:0] STG_LINK_R_FROM_L = 2'h2;

    // Processing mode that holds the tone generator.
    localparam int STG_MODE_W = 5;
    localparam logic [4:0] STG_TONE_MODE = 5'h19;

    // Oscillator and gain arithmetic.
    localparam logic signed [15:0] STG_OSC_AMP = 16'sh6000;
    localparam int STG_COEF_FRAC = 15;
    localparam int STG_GAIN_FRAC = 14;
    localparam logic [5:0] STG_DB_PER_SHIFT = 6'h06;
    localparam logic [14:0] STG_MANT_P2 = 15'h5092;
    localparam logic [14:0] STG_MANT_P1 = 15'h47cf;
    localparam logic [14:0] STG_MANT_0 = 15'h4000;
    localparam logic [14:0] STG_MANT_M1 = 15'h390a;
    localparam logic [14:0] STG_MANT_M2 = 15'h32d6;
    localparam logic [14:0] STG_MANT_M3 = 15'h2d4f;

    typedef struct packed {
        logic ena;
        logic rsv;
        logic [5:0] vol;
    } stg_lctl_t;

    typedef struct packed {
        logic [1:0] link;
        logic [5:0] vol;
    } stg_rctl_t;

    typedef struct packed {
        logic signed [15:0] left;
        logic signed [15:0] right;
    } stg_pair_t;

    typedef enum logic {STG_IDLE, STG_RUN} stg_state_t;
endpackage

//--- rtl/stg_top.sv
// Sine tone generator: page-0 tone registers, duration counter and volume.
//
// Functional notes
// RL1 - Writing one to enable starts a tone; hardware clears it after the duration.
// RL2 - With enable at zero the generator is idle and outputs silence; the last sample of a tone still leaves, valid, one cycle after enable clears.
// RL3 - Left volume code 0 is +2 dB, minus 1 dB per step, -61 dB at 63.
// RL4 - Right volume code 0 is +2 dB, minus 1 dB per step, -61 dB at 63.
// RL5 - Link code 00 or 11 gives each channel its own volume.
// RL6 - Link code 01 makes the left channel use the right volume.
// RL7 - Link code 10 makes the right channel use the left volume.
// RL8 - Tones run only in the processing mode that contains the generator.
// RL9 - Duration is a 24-bit sample count from high, middle and low bytes.
// RL10 - Duration low byte resets to 0xee, middle and high bytes to zero.
// RL11 - Sine coefficient is 16 bits in two bytes, reset 0x10d8.
// RL12 - Cosine coefficient is 16 bits in two bytes, reset 0x7ee3.
// RL13 - One tone sample is produced per playback sample period.
// RL14 - Software writes only the reset value to the reserved left-control bit.
// RL15 - Software leaves the reserved range after the coefficients alone.
// RL16 - Tone registers sit in page zero; offset zero selects the page.
// RL17 - A coupled-form recursive oscillator makes the sinusoid.
// RL18 - A counter loads the duration, counts samples, and ends the tone at zero.
// RL19 - Each channel is scaled by its gain after volume linking.
`timescale 1ns/1ns
module stg_top import stg_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata_q,
    input wire logic sample_tick,
    input wire logic [STG_MODE_W-1:0] proc_mode,
    output stg_pair_t tone_q,
    output logic tone_valid_q,
    output logic tone_active
);
    logic [7:0] page_q;
    stg_lctl_t lctl_q;
    stg_rctl_t rctl_q;
    logic [23:0] len_q;
    logic [15:0] sin_q;
    logic [15:0] cos_q;
    logic [23:0] cnt_q;
    logic [23:0] cnt_d;
    stg_state_t state_q;
    stg_state_t state_d;
    logic on_page;
    logic wr_lctl;
    logic start;
    logic done;
    logic mode_ok;
    logic emit;
    logic emit_q;
    logic [5:0] vol_l;
    logic [5:0] vol_r;
    logic signed [15:0] sine;
    logic signed [15:0] out_l;
    logic signed [15:0] out_r;

    // Page select decode; the page register answers on every page.
    assign on_page = (page_q == STG_TONE_PAGE); // see RL16
    assign wr_lctl = reg_we && on_page && (reg_addr == STG_LCTL_OFS);
    assign mode_ok = (proc_mode == STG_TONE_MODE); // see RL8
    // A start needs the tone-capable mode; otherwise the write leaves enable low.
    assign start = wr_lctl && reg_wdata[STG_ENA_BIT] && mode_ok; // see RL1

    // Page register, writable at offset zero of any page.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            page_q <= STG_PAGE_RST;
        end else if (reg_we && reg_addr == STG_PAGE_OFS) begin
            page_q <= reg_wdata; // see RL16
        end
    end

    // Volume, link, duration and coefficient registers of page zero.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lctl_q <= STG_CTL_RST;
            rctl_q <= STG_CTL_RST;
            len_q <= {STG_LENH_RST, STG_LENM_RST, STG_LENL_RST}; // see RL10
            sin_q <= {STG_SINH_RST, STG_SINL_RST}; // see RL11
            cos_q <= {STG_COSH_RST, STG_COSL_RST}; // see RL12
        end else begin
            // Enable is fed from the next run state, so it clears itself as the tone ends.
            lctl_q.ena <= (state_d == STG_RUN); // see RL1
            if (reg_we && on_page) begin
                case (reg_addr)
                    STG_LCTL_OFS: begin
                        // The reserved bit is stored as written; software keeps it at reset.
                        lctl_q.rsv <= reg_wdata[STG_RSV_BIT]; // see RL14
                        lctl_q.vol <= reg_wdata[STG_VOL_W-1:0];
                    end
                    STG_RCTL_OFS: rctl_q <= reg_wdata;
                    STG_LENH_OFS: len_q[23:16] <= reg_wdata; // see RL9
                    STG_LENM_OFS: len_q[15:8] <= reg_wdata;
                    STG_LENL_OFS: len_q[7:0] <= reg_wdata;
                    STG_SINH_OFS: sin_q[15:8] <= reg_wdata;
                    STG_SINL_OFS: sin_q[7:0] <= reg_wdata;
                    STG_COSH_OFS: cos_q[15:8] <= reg_wdata;
                    STG_COSL_OFS: cos_q[7:0] <= reg_wdata;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data is registered: it appears the cycle after the read strobe.
    // Unused offsets, including the reserved range, read as zero.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_re) begin
            if (reg_addr == STG_PAGE_OFS) begin
                reg_rdata_q <= page_q;
            end else if (!on_page) begin
                reg_rdata_q <= 8'h00;
            end else begin
                case (reg_addr)
                    STG_LCTL_OFS: reg_rdata_q <= lctl_q;
                    STG_RCTL_OFS: reg_rdata_q <= rctl_q;
                    STG_LENH_OFS: reg_rdata_q <= len_q[23:16];
                    STG_LENM_OFS: reg_rdata_q <= len_q[15:8];
                    STG_LENL_OFS: reg_rdata_q <= len_q[7:0];
                    STG_SINH_OFS: reg_rdata_q <= sin_q[15:8];
                    STG_SINL_OFS: reg_rdata_q <= sin_q[7:0];
                    STG_COSH_OFS: reg_rdata_q <= cos_q[15:8];
                    STG_COSL_OFS: reg_rdata_q <= cos_q[7:0];
                    default: reg_rdata_q <= 8'h00; // see RL15
                endcase
            end
        end
    end

    // Run control: emit one sample per tick while counts remain.
    // A zero duration ends on the first tick without emitting anything.
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        emit = 1'b0;
        done = 1'b0;
        case (state_q)
            STG_IDLE: begin
                if (start) begin
                    state_d = STG_RUN;
                    cnt_d = len_q; // see RL18
                end
            end
            STG_RUN: begin
                if (!mode_ok || (wr_lctl && !reg_wdata[STG_ENA_BIT])) begin
                    // Leaving the mode or writing zero stops at once.
                    state_d = STG_IDLE; // see RL8
                    done = 1'b1;
                end else if (sample_tick) begin
                    emit = (cnt_q != 24'h00_0000); // see RL13
                    cnt_d = (cnt_q == 24'h00_0000) ? cnt_q : cnt_q - 24'h00_0001;
                    if (cnt_q <= 24'h00_0001) begin
                        state_d = STG_IDLE;
                        done = 1'b1; // see RL18
                    end
                end
                // A new start write wins over the end of the running tone.
                if (start) begin
                    state_d = STG_RUN;
                    cnt_d = len_q;
                    done = 1'b0;
                    // A restart is not counted, so it must not emit a sample either.
                    emit = 1'b0;
                end
            end
            default: state_d = STG_IDLE;
        endcase
    end

    // State and sample counter.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= STG_IDLE;
            cnt_q <= 24'h00_0000;
            emit_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            emit_q <= emit;
        end
    end

    // Enable bit and run state load from the same next state, so they never disagree.
    assign tone_active = lctl_q.ena; // see RL1

    // Volume linking picks which programmed code drives each channel.
    always_comb begin
        vol_l = lctl_q.vol; // see RL5
        vol_r = rctl_q.vol;
        if (rctl_q.link == STG_LINK_L_FROM_R) begin
            vol_l = rctl_q.vol; // see RL6
        end
        if (rctl_q.link == STG_LINK_R_FROM_L) begin
            vol_r = lctl_q.vol; // see RL7
        end
    end

    // Oscillator restarts on each start and steps once per emitted sample.
    stg_osc u_osc ( // see RL17
        .core_clk(core_clk),
        .rst_n(rst_n),
        .start(start),
        .step(emit),
        .sin_coef($signed(sin_q)),
        .cos_coef($signed(cos_q)),
        .sine_q(sine)
    );

    // One gain stage per channel; they stay live one cycle past the end so the last sample gets out.
    stg_gain u_gain_l ( // see RL3
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(tone_active || emit_q), // see RL2
        .in_valid(emit_q),
        .in_sample(sine),
        .vol_code(vol_l), // see RL19
        .out_sample_q(out_l)
    );

    stg_gain u_gain_r ( // see RL4
        .core_clk(core_clk),
        .rst_n(rst_n),
        .run(tone_active || emit_q),
        .in_valid(emit_q),
        .in_sample(sine),
        .vol_code(vol_r), // see RL19
        .out_sample_q(out_r)
    );

    assign tone_q.left = out_l;
    assign tone_q.right = out_r;

    // Valid lines up with the gain outputs, one cycle after the tick edge, last sample included.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tone_valid_q <= 1'b0;
        end else begin
            tone_valid_q <= emit_q; // see RL9
        end
    end

    // Checks next to the logic they guard.
    a_start_loads_count: assert property ( // see RL18
        @(posedge core_clk) disable iff (!rst_n)
        start |=> (state_q == STG_RUN) && (cnt_q == $past(len_q)))
        else $error("start did not load the duration");

    a_enable_self_clear: assert property ( // see RL1
        @(posedge core_clk) disable iff (!rst_n)
        (state_q == STG_RUN) && sample_tick && mode_ok && (cnt_q == 24'h00_0001) && !wr_lctl
        |=> !lctl_q.ena)
        else $error("enable did not clear at the end of the tone");

    a_idle_is_silent: assert property ( // see RL2
        @(posedge core_clk) disable iff (!rst_n)
        !lctl_q.ena [*3] |-> (out_l == 16'sh0000) && (out_r == 16'sh0000) && !tone_valid_q)
        else $error("tone output while disabled");

    a_mode_gates_start: assert property ( // see RL8
        @(posedge core_clk) disable iff (!rst_n)
        !lctl_q.ena && !mode_ok |=> !lctl_q.ena)
        else $error("tone started outside the tone mode");

    a_count_one_step: assert property ( // see RL13
        @(posedge core_clk) disable iff (!rst_n)
        (state_q == STG_RUN) && mode_ok && sample_tick && !wr_lctl && (cnt_q > 24'h00_0001)
        |=> (cnt_q == $past(cnt_q) - 24'h00_0001) ##1 tone_valid_q)
        else $error("sample step or output missing");

    a_link_left_vol: assert property ( // see RL6
        @(posedge core_clk) disable iff (!rst_n)
        (rctl_q.link == STG_LINK_L_FROM_R) |-> (vol_l == rctl_q.vol) && (vol_r == rctl_q.vol))
        else $error("left link volume wrong");

    a_link_right_vol: assert property ( // see RL7
        @(posedge core_clk) disable iff (!rst_n)
        (rctl_q.link == STG_LINK_R_FROM_L) |-> (vol_r == lctl_q.vol) && (vol_l == lctl_q.vol))
        else $error("right link volume wrong");

    a_link_independent: assert property ( // see RL5
        @(posedge core_clk) disable iff (!rst_n)
        (rctl_q.link == 2'h0 || rctl_q.link == 2'h3) |-> (vol_l == lctl_q.vol) && (vol_r == rctl_q.vol))
        else $error("independent volumes wrong");

    a_length_reset: assert property ( // see RL10
        @(posedge core_clk)
        !rst_n |=> (len_q == 24'h00_00ee) && (sin_q == 16'h10d8) && (cos_q == 16'h7ee3))
        else $error("reset values wrong");

    a_page_gates_write: assert property ( // see RL16
        @(posedge core_clk) disable iff (!rst_n)
        reg_we && !on_page && (reg_addr == STG_LENL_OFS) |=> $stable(len_q))
        else $error("write reached tone registers off page zero");

    a_done_clears_enable: assert property ( // see RL18
        @(posedge core_clk) disable iff (!rst_n)
        done |=> !lctl_q.ena)
        else $error("enable still set after the tone ended");

    a_clear_stops_tone: assert property ( // see RL2
        @(posedge core_clk) disable iff (!rst_n)
        lctl_q.ena && wr_lctl && !reg_wdata[STG_ENA_BIT] |=> !lctl_q.ena)
        else $error("writing zero to enable did not stop the tone");

    a_mode_exit_stops: assert property ( // see RL8
        @(posedge core_clk) disable iff (!rst_n)
        lctl_q.ena && !mode_ok |=> !lctl_q.ena)
        else $error("tone kept running outside the tone mode");

    a_emit_needs_tick: assert property ( // see RL13
        @(posedge core_clk) disable iff (!rst_n)
        emit |-> sample_tick && (state_q == STG_RUN) && (cnt_q != 24'h00_0000))
        else $error("sample emitted without a tick or count");

    a_valid_follows_emit: assert property ( // see RL13
        @(posedge core_clk) disable iff (!rst_n)
        emit_q |=> tone_valid_q)
        else $error("emitted sample never marked valid");

    a_reserved_bit_kept: assert property ( // see RL14
        @(posedge core_clk) disable iff (!rst_n)
        wr_lctl |=> (lctl_q.rsv == $past(reg_wdata[STG_RSV_BIT])))
        else $error("reserved control bit not stored");

    a_sine_coef_write: assert property ( // see RL11
        @(posedge core_clk) disable iff (!rst_n)
        reg_we && on_page && (reg_addr == STG_SINH_OFS) |=> (sin_q[15:8] == $past(reg_wdata)))
        else $error("sine coefficient high byte not written");

    a_cosine_coef_write: assert property ( // see RL12
        @(posedge core_clk) disable iff (!rst_n)
        reg_we && on_page && (reg_addr == STG_COSL_OFS) |=> (cos_q[7:0] == $past(reg_wdata)))
        else $error("cosine coefficient low byte not written");

    a_length_mid_write: assert property ( // see RL9
        @(posedge core_clk) disable iff (!rst_n)
        reg_we && on_page && (reg_addr == STG_LENM_OFS) |=> (len_q[15:8] == $past(reg_wdata)))
        else $error("duration middle byte not written");

    a_start_resets_phase: assert property ( // see RL17
        @(posedge core_clk) disable iff (!rst_n)
        start |=> (sine == 16'sh0000))
        else $error("oscillator phase not restarted");
endmodule

//--- testbench/stg_top_test.sv
// Self-checking testbench of the sine tone generator top level.
`timescale 1ns/1ns
module stg_top_test import stg_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_we = 1'b0;
    logic reg_re = 1'b0;
    logic [7:0] reg_rdata_q;
    logic sample_tick = 1'b0;
    logic [STG_MODE_W-1:0] proc_mode = STG_TONE_MODE;
    stg_pair_t tone_q;
    logic tone_valid_q;
    logic tone_active;
    int num_errors = 0;
    int check_count = 0;
    logic [7:0] rd_exp_q[$];
    logic rd_pend = 1'b0;
    int n_samp = 0;
    logic [15:0] max_l = 16'h0000;
    logic [15:0] max_r = 16'h0000;
    logic want_eq = 1'b0;

    stg_top i_stg_top (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_we(reg_we),
        .reg_re(reg_re),
        .reg_rdata_q(reg_rdata_q),
        .sample_tick(sample_tick),
        .proc_mode(proc_mode),
        .tone_q(tone_q),
        .tone_valid_q(tone_valid_q),
        .tone_active(tone_active)
    );

    // The 25 MHz core clock.
    initial begin
        forever #20 core_clk = ~core_clk;
    end

    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check16(string what, logic [15:0] exp, logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic conclude();
        $display("Totals: %0d comparisons, %0d mismatches", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    function automatic logic [15:0] mag(logic signed [15:0] v);
        return v[15] ? 16'(-v) : v;
    endfunction

    // Register write: one-cycle strobe, then a quiet cycle so strobes never merge.
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_we = 1'b1;
        @(negedge core_clk);
        reg_we = 1'b0;
    endtask

    // Register read: the expected byte is queued and checked by the watcher.
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(negedge core_clk);
        reg_addr = a;
        reg_re = 1'b1;
        rd_exp_q.push_back(e);
        @(negedge core_clk);
        reg_re = 1'b0;
    endtask

    // Playback sample strobe; gap of at least two keeps the output pipeline clean.
    task automatic tick(int gap);
        @(negedge core_clk);
        sample_tick = 1'b1;
        @(negedge core_clk);
        sample_tick = 1'b0;
        repeat (gap) @(negedge core_clk);
    endtask

    task automatic start(logic [23:0] len, logic [7:0] lctl_v, logic [7:0] rctl_v);
        wr(STG_RCTL_OFS, rctl_v);
        wr(STG_LENH_OFS, len[23:16]);
        wr(STG_LENM_OFS, len[15:8]);
        wr(STG_LENL_OFS, len[7:0]);
        n_samp = 0;
        max_l = 16'h0000;
        max_r = 16'h0000;
        wr(STG_LCTL_OFS, lctl_v | 8'h80);
    endtask

    // Ticks with random spacing until the tone ends by itself, bounded by limit.
    task automatic run_out(int limit);
        for (int k = 0; k < limit && tone_active === 1'b1; k++) begin
            tick($urandom_range(2, 5));
        end
        repeat (3) @(negedge core_clk);
    endtask

    task automatic check_peaks(string what, logic [15:0] lo, logic [15:0] hi, logic [15:0] v);
        check16(what, 16'h0001, {15'h0000, (v >= lo && v <= hi)});
    endtask

    // Watcher: read data one cycle after the strobe, tone samples on each valid pulse.
    always @(posedge core_clk) begin
        rd_pend <= reg_re & rst_n;
    end
    always @(negedge core_clk) begin
        if (rd_pend) begin
            check8("read data", rd_exp_q.pop_front(), reg_rdata_q);
        end
        if (tone_valid_q === 1'b1) begin
            n_samp++;
            if (mag(tone_q.left) > max_l) begin
                max_l = mag(tone_q.left);
            end
            if (mag(tone_q.right) > max_r) begin
                max_r = mag(tone_q.right);
            end
            if (want_eq) begin
                check16("linked sample", tone_q.left, tone_q.right);
            end
        end
    end

    // Watchdog: the tests need well under 10000 cycles.
    initial begin
        #800000;
        num_errors++;
        conclude();
    end

    initial begin
        logic [7:0] rst_tab [9];
        logic [7:0] rnd;
        int d;
        rst_tab = '{STG_CTL_RST, STG_CTL_RST, STG_LENH_RST, STG_LENM_RST, STG_LENL_RST,
                    STG_SINH_RST, STG_SINL_RST, STG_COSH_RST, STG_COSL_RST};
        void'($urandom(32'h81e5));
        repeat (8) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        rd(STG_PAGE_OFS, 8'h00);
        for (int i = 0; i < 9; i++) begin
            rd(STG_LCTL_OFS + 8'(i), rst_tab[i]);
        end
        // Unmapped offsets on either side read zero; the reserved range itself is never touched.
        rd(STG_LCTL_OFS - 8'h01, 8'h00);
        rd(STG_RSV_HI_OFS + 8'h01, 8'h00);
        $display("Test reset_values done");
        for (int i = 1; i < 9; i++) begin
            rnd = 8'($urandom);
            wr(STG_LCTL_OFS + 8'(i), rnd);
            rd(STG_LCTL_OFS + 8'(i), rnd);
        end
        // Random coefficients would make the oscillator grow or die away, so restore them.
        for (int i = 5; i < 9; i++) begin
            wr(STG_LCTL_OFS + 8'(i), rst_tab[i]);
        end
        proc_mode = 5'h00;
        wr(STG_LCTL_OFS, 8'hbf);
        rd(STG_LCTL_OFS, 8'h3f);
        proc_mode = STG_TONE_MODE;
        wr(STG_LCTL_OFS, 8'h00);
        wr(STG_RSV_HI_OFS + 8'h01, 8'ha5);
        rd(STG_RSV_HI_OFS + 8'h01, 8'h00);
        wr(STG_LENL_OFS, 8'h5c);
        wr(STG_PAGE_OFS, 8'h01);
        wr(STG_LENL_OFS, 8'h33);
        rd(STG_PAGE_OFS, 8'h01);
        wr(STG_PAGE_OFS, 8'h00);
        rd(STG_LENL_OFS, 8'h5c);
        $display("Test register_access done");
        start(24'h000103, 8'h00, 8'h00);
        rd(STG_LCTL_OFS, 8'h80);
        run_out(300);
        check16("sample count", 16'd259, 16'(n_samp));
        rd(STG_LCTL_OFS, 8'h00);
        check16("idle left", 16'h0000, tone_q.left);
        check_peaks("plus two dB peak", 16'd29900, 16'd31900, max_l);
        $display("Test duration done");
        for (int k = 0; k < 2; k++) begin
            start(24'h00003c, 8'h00, (k == 0) ? 8'h06 : 8'hc6);
            run_out(80);
            d = int'(max_l) - 2 * int'(max_r);
            check_peaks("six codes halve", 16'd0, 16'd128, 16'(d + 64));
        end
        start(24'h00003c, 8'h3f, 8'h00);
        run_out(80);
        check_peaks("minus 61 dB peak", 16'd15, 16'd30, max_l);
        $display("Test volume done");
        want_eq = 1'b1;
        start(24'h00003c, 8'h3f, 8'h40);
        run_out(80);
        check_peaks("left follows right", 16'd29900, 16'd31900, max_l);
        start(24'h00003c, 8'h00, 8'hbf);
        run_out(80);
        check_peaks("right follows left", 16'd29900, 16'd31900, max_r);
        want_eq = 1'b0;
        $display("Test link done");
        start(24'h000064, 8'h00, 8'h00);
        repeat (3) tick(3);
        wr(STG_LCTL_OFS, 8'h00);
        repeat (2) @(negedge core_clk);
        check8("active after clear", 8'h00, {7'h00, tone_active});
        check16("output after clear", 16'h0000, tone_q.right);
        start(24'h000064, 8'h00, 8'h00);
        repeat (3) tick(3);
        proc_mode = 5'h00;
        repeat (2) @(negedge core_clk);
        check8("active off mode", 8'h00, {7'h00, tone_active});
        proc_mode = STG_TONE_MODE;
        start(24'h000000, 8'h00, 8'h00);
        tick(3);
        check8("zero length ends", 8'h00, {7'h00, tone_active});
        check16("zero length samples", 16'd0, 16'(n_samp));
        $display("Test stop done");
        repeat (3) @(negedge core_clk);
        conclude();
    end
endmodule
